// ---- logic/usi_irq.sv ----
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module usi_irq
	import usi_pkg::*;
#(
	parameter int IDLE_CNT = IDLE_CYCLES
) (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic [2:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	input  wire logic       BUS_ACTIVITY,
	input  wire logic [7:0] STATUS_EVENT,
	input  wire logic [7:0] ERROR_EVENT,
	output logic            PERIPHERAL_IRQ_REQUEST,
	output logic            PULLUP_EN,
	output logic            SUSPENDED
);
	logic [7:0]  peripheral_control_reg;
	logic [7:0]  status_flag_reg;
	logic [7:0]  status_enable_reg;
	logic [7:0]  error_flag_reg;
	logic [7:0]  error_enable_reg;
	logic        act_s1;
	logic        act_s2;
	logic        act_armed;
	logic [31:0] idle_cnt;
	logic [3:0]  wake_cnt;
	logic        idle_hit;
	logic        clr_block;
	logic        st_wr;
	logic        er_wr;
	logic [7:0]  st_clr;
	logic [7:0]  next_status;
	logic [7:0]  next_error;
	logic [7:0]  next_stat_en;
	logic        error_summary_flag;

	// Pin sync
	always_ff @(posedge CLK) begin
		act_s1 <= BUS_ACTIVITY;
		act_s2 <= act_s1;
	end

	// Idle timer
	always_ff @(posedge CLK) begin
		if (RST || act_s2) begin
			idle_cnt <= 32'h0;
		end else if (idle_cnt < IDLE_CNT) begin
			idle_cnt <= idle_cnt + 32'h1;
		end
	end
	assign idle_hit = !act_s2 && (idle_cnt == IDLE_CNT - 1);

	// Wake resync window
	always_ff @(posedge CLK) begin
		if (RST) begin
			wake_cnt <= 4'h0;
		end else if (peripheral_control_reg[BIT_SUSPEND]) begin
			wake_cnt <= 4'(WAKE_SYNC_CYC);
		end else if (wake_cnt != 4'h0) begin
			wake_cnt <= wake_cnt - 4'h1;
		end
	end
	assign clr_block = peripheral_control_reg[BIT_SUSPEND] || (wake_cnt != 4'h0);

	// Activity arm: one flag per idle period
	always_ff @(posedge CLK) begin
		if (RST) begin
			act_armed <= 1'b0;
		end else if (idle_hit || peripheral_control_reg[BIT_SUSPEND]) begin
			act_armed <= 1'b1;
		end else if (act_s2) begin
			act_armed <= 1'b0;
		end
	end

	assign st_wr = WR && (ADDR == ADDR_STATUS);
	assign er_wr = WR && (ADDR == ADDR_ERR);
	assign error_summary_flag = |(error_flag_reg & error_enable_reg);

	always_comb begin
		st_clr = (WR && ADDR == ADDR_CLR) ? WDATA : 8'h00;
		if (clr_block) begin
			st_clr[BIT_ACTIVITY] = 1'b0;
		end
		next_status = status_flag_reg & ~st_clr;
		next_status = next_status | STATUS_EVENT;
		if (st_wr) begin
			next_status = next_status | WDATA;
		end
		next_status[BIT_IDLE] = next_status[BIT_IDLE] | idle_hit;
		next_status[BIT_ACTIVITY] = next_status[BIT_ACTIVITY] | (act_armed && act_s2);
		next_status[BIT_ERR_SUM] = error_summary_flag;
		next_error = error_flag_reg;
		if (WR && ADDR == ADDR_CLR) begin
			next_error = 8'h00;
		end
		if (er_wr) begin
			next_error = error_flag_reg & ~WDATA;
		end
		next_error = next_error | ERROR_EVENT;
		next_stat_en = (WR && ADDR == ADDR_STAT_EN) ? WDATA : status_enable_reg;
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			status_flag_reg <= RST_REG;
			error_flag_reg  <= RST_REG;
		end else begin
			status_flag_reg <= next_status;
			error_flag_reg  <= next_error;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			peripheral_control_reg <= RST_REG;
			status_enable_reg      <= RST_REG;
			error_enable_reg       <= RST_REG;
		end else if (WR) begin
			if (ADDR == ADDR_CTRL) begin
				peripheral_control_reg <= WDATA;
			end
			if (ADDR == ADDR_STAT_EN) begin
				status_enable_reg <= WDATA;
			end
			if (ADDR == ADDR_ERR_EN) begin
				error_enable_reg <= WDATA;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			PERIPHERAL_IRQ_REQUEST <= 1'b0;
			PULLUP_EN              <= 1'b0;
			SUSPENDED              <= 1'b0;
		end else begin
			PERIPHERAL_IRQ_REQUEST <= |(next_status & next_stat_en);
			PULLUP_EN <= peripheral_control_reg[BIT_PULLUP] && peripheral_control_reg[BIT_ENABLE];
			SUSPENDED <= peripheral_control_reg[BIT_SUSPEND];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				ADDR_CTRL:    RDATA <= peripheral_control_reg;
				ADDR_STATUS:  RDATA <= status_flag_reg;
				ADDR_STAT_EN: RDATA <= status_enable_reg;
				ADDR_ERR:     RDATA <= error_flag_reg;
				ADDR_ERR_EN:  RDATA <= error_enable_reg;
				default:      RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	AST_IRQ_GATE: assert property (@(posedge CLK) disable iff (RST)
		(status_flag_reg & status_enable_reg) == 8'h00 |-> !PERIPHERAL_IRQ_REQUEST)
		else $error("irq without enabled flag");
	AST_SUMMARY: assert property (@(posedge CLK) disable iff (RST)
		##1 status_flag_reg[BIT_ERR_SUM] == |($past(error_flag_reg) & $past(error_enable_reg)))
		else $error("error summary mismatch");
	AST_CLR_BLOCK: assert property (@(posedge CLK) disable iff (RST)
		clr_block && status_flag_reg[BIT_ACTIVITY] |=> status_flag_reg[BIT_ACTIVITY])
		else $error("activity cleared while blocked");
	AST_ERR_SET: assert property (@(posedge CLK) disable iff (RST)
		|ERROR_EVENT |=> (error_flag_reg & $past(ERROR_EVENT)) == $past(ERROR_EVENT))
		else $error("error flag not set");
	AST_ERR_HOLD: assert property (@(posedge CLK) disable iff (RST)
		!WR |=> (error_flag_reg & $past(error_flag_reg)) == $past(error_flag_reg))
		else $error("error flag dropped");
	AST_POLL: assert property (@(posedge CLK) disable iff (RST)
		|STATUS_EVENT |=> (status_flag_reg & $past(STATUS_EVENT)) == $past(STATUS_EVENT))
		else $error("status flag not set");
	AST_DBG_SET: assert property (@(posedge CLK) disable iff (RST)
		st_wr && WDATA[BIT_ACTIVITY] |=> status_flag_reg[BIT_ACTIVITY])
		else $error("debug set failed");
	AST_ONE_ACT: assert property (@(posedge CLK) disable iff (RST)
		!act_armed && !status_flag_reg[BIT_ACTIVITY] && !STATUS_EVENT[BIT_ACTIVITY] && !st_wr
		|=> !status_flag_reg[BIT_ACTIVITY])
		else $error("activity flag rose unarmed");
endmodule : usi_irq

// ---- logic/usi_pkg.sv ----
// Notes on behaviour
// - Clears of bus activity flag ignored while suspended and briefly after wake.
// - With PLL clock, firmware waits for lock after leaving suspend.
// - Bus activity flag rises only once per resume from bus idle.
// - After clear, activity flag stays low until a new bus idle or a suspend occurs.
// - Each status enable bit lets its flag reach the interrupt request.
// - Flags set regardless of enables; enables gate only the interrupt path.
// - Error summary flag is OR of error flags with enable bits set.
// - Error flags set immediately when the error condition is detected.
// - Error flags stay set until firmware clears them.
// - Bus idle flag sets after more than 3 ms without addressed traffic.
// - Data line pull-up enable stays asserted during suspend.
// - All enabled status flags OR into one peripheral interrupt request.
// - Writing one to a status flag other than the error summary flag sets it, for debugging.
package usi_pkg;
	localparam logic [2:0] ADDR_CTRL     = 3'h0;
	localparam logic [2:0] ADDR_STATUS   = 3'h1;
	localparam logic [2:0] ADDR_STAT_EN  = 3'h2;
	localparam logic [2:0] ADDR_ERR      = 3'h3;
	localparam logic [2:0] ADDR_ERR_EN   = 3'h4;
	localparam logic [2:0] ADDR_CLR      = 3'h5;
	localparam int         BIT_ERR_SUM   = 1;
	localparam int         BIT_ACTIVITY  = 2;
	localparam int         BIT_IDLE      = 4;
	localparam int         BIT_SUSPEND   = 1;
	localparam int         BIT_PULLUP    = 2;
	localparam int         BIT_ENABLE    = 3;
	localparam logic [7:0] RST_REG       = 8'h00;
	localparam int         CLK_HZ        = 20000000;
	localparam int         IDLE_US       = 3000;
	localparam int         IDLE_CYCLES   = (IDLE_US * (CLK_HZ / 1000000)) + 1;
	localparam int         WAKE_SYNC_CYC = 4;
endpackage : usi_pkg

// ---- verif/test_usi_irq.sv ----
`timescale 1ns/1ps
module test_usi_irq;
	import usi_pkg::*;
	logic       CLK = 0;
	logic       RST = 1;
	logic       WR = 0;
	logic       RD = 0;
	logic       talk = 0;
	logic [2:0] ADDR = 0;
	logic [7:0] WDATA = 0;
	logic [7:0] EV = 0;
	logic [7:0] SEV = 0;
	logic [7:0] RDATA;
	logic       BUS_ACTIVITY;
	logic       IRQ;
	logic       PULLUP_EN;
	logic       SUSPENDED;
	logic [7:0] eb;
	int         fails = 0;
	int         samples_checked = 0;
	int         cyc = 0;
	always #25 CLK = ~CLK;
	usi_host_model usi_host_model_inst (.CLK(CLK), .talk(talk), .BUS_ACTIVITY(BUS_ACTIVITY));
	usi_irq #(.IDLE_CNT(20)) usi_irq_inst (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .BUS_ACTIVITY(BUS_ACTIVITY), .STATUS_EVENT(SEV), .ERROR_EVENT(EV),
		.PERIPHERAL_IRQ_REQUEST(IRQ), .PULLUP_EN(PULLUP_EN), .SUSPENDED(SUSPENDED));
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge CLK);
		WR <= 1;
		ADDR <= a;
		WDATA <= d;
		@(posedge CLK);
		WR <= 0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
		@(posedge CLK);
		RD <= 1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 0;
		#1 chk(RDATA & m, exp);
	endtask : rd
	task automatic ev(input logic [7:0] d);
		@(posedge CLK);
		EV <= d;
		@(posedge CLK);
		EV <= 8'h00;
	endtask : ev
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			final_report;
		end
	end
	initial begin
		void'($urandom(32'h4B6E));
		eb = 8'h01 << ($urandom % 8);
		repeat (4) @(posedge CLK);
		RST <= 0;
		rd(ADDR_STATUS, 8'hFF, 8'h00);
		rd(3'h7, 8'hFF, 8'h00);
		repeat (25) @(posedge CLK);
		rd(ADDR_STATUS, 8'h14, 8'h10);
		wr(ADDR_CLR, 8'h10);
		talk <= 1;
		repeat (6) @(posedge CLK);
		rd(ADDR_STATUS, 8'h14, 8'h04);
		wr(ADDR_CLR, 8'h04);
		repeat (8) @(posedge CLK);
		rd(ADDR_STATUS, 8'h14, 8'h00);
		wr(ADDR_ERR_EN, 8'hFF);
		wr(ADDR_STAT_EN, 8'h02);
		ev(eb);
		rd(ADDR_ERR, 8'hFF, eb);
		rd(ADDR_STATUS, 8'h02, 8'h02);
		chk({7'h00, IRQ}, 8'h01);
		wr(ADDR_STAT_EN, 8'h00);
		@(posedge CLK);
		#1 chk({7'h00, IRQ}, 8'h00);
		rd(ADDR_STATUS, 8'h02, 8'h02);
		rd(ADDR_ERR, 8'hFF, eb);
		wr(ADDR_ERR, eb);
		wr(ADDR_ERR_EN, 8'h00);
		ev(eb);
		rd(ADDR_ERR, 8'hFF, eb);
		rd(ADDR_STATUS, 8'h02, 8'h00);
		@(posedge CLK);
		SEV <= 8'h08;
		@(posedge CLK);
		SEV <= 8'h00;
		rd(ADDR_STATUS, 8'h08, 8'h08);
		talk <= 0;
		wr(ADDR_CTRL, 8'h0E);
		@(posedge CLK);
		#1 chk({6'h00, PULLUP_EN, SUSPENDED}, 8'h03);
		wr(ADDR_STATUS, 8'h04);
		rd(ADDR_STATUS, 8'h04, 8'h04);
		wr(ADDR_CLR, 8'h04);
		rd(ADDR_STATUS, 8'h04, 8'h04);
		wr(ADDR_CTRL, 8'h0C);
		wr(ADDR_CLR, 8'h04);
		rd(ADDR_STATUS, 8'h04, 8'h04);
		repeat (6) wr(ADDR_CLR, 8'h04);
		rd(ADDR_STATUS, 8'h04, 8'h00);
		final_report;
	end
endmodule : test_usi_irq

// ---- verif/usi_host_model.sv ----
`timescale 1ns/1ps
module usi_host_model (
	input  wire logic CLK,
	input  wire logic talk,
	output logic      BUS_ACTIVITY
);
	// Addressed traffic holds the line high, silence holds it low
	always_ff @(posedge CLK) begin
		BUS_ACTIVITY <= talk;
	end
endmodule : usi_host_model
